// ---- hw/gpl_pkg.sv ----
package gpl_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [11:0] IDX_MAX_FRAME   = 12'h00F;
  localparam logic [11:0] IDX_FLOW_CONTROL_ENABLE   = 12'h012;
  localparam logic [11:0] IDX_RX_CFG      = 12'h016;
  localparam logic [11:0] IDX_ADV_CFG     = 12'h017;
  localparam logic [11:0] IDX_MISC_CFG    = 12'h018;
  localparam logic [11:0] IDX_RX_OCTETS   = 12'h020;
  localparam logic [11:0] IDX_RX_JUMBO    = 12'h02B;
  localparam logic [11:0] IDX_RX_CRC_ERR  = 12'h02C;
  localparam logic [11:0] IDX_RX_DATA_ERR = 12'h02E;
  localparam logic [11:0] IDX_RX_ALIGN    = 12'h02F;
  localparam logic [11:0] IDX_RX_LONG     = 12'h030;
  localparam logic [11:0] IDX_RX_JABBER   = 12'h031;
  localparam logic [11:0] IDX_RX_VLONG    = 12'h034;
  localparam logic [11:0] IDX_TX_OCTETS   = 12'h040;
  localparam logic [11:0] IDX_TX_JUMBO    = 12'h04B;
  localparam logic [11:0] IDX_TX_LONG_DRP = 12'h053;
  localparam logic [11:0] IDX_TX_CRC_ERR  = 12'h056;
  localparam logic [11:0] IDX_LINK_LED    = 12'h502;

  // Field positions
  localparam int BIT_AN_SELECT  = 5;
  localparam int BIT_TX_CRC_APP = 6;
  localparam int BIT_RX_SYNC    = 20;
  localparam int BIT_AN_DONE    = 21;
  localparam int BIT_FC_RX      = 0;
  localparam int BIT_FC_TX      = 1;

  // Reset values and frame limits
  localparam logic [13:0] RST_MAX_FRAME = 14'h05EE;
  localparam logic [31:0] RST_MISC_CFG  = 32'h0000_0000;
  localparam logic [31:0] RST_FLOW_CONTROL_ENABLE = 32'h0000_0003;
  localparam logic [14:0] JUMBO_MIN_LEN = 15'h05EF;
  localparam logic [14:0] VLAN_EXTRA    = 15'h0004;

  // SPI4-2 transmit FIFO status codes
  localparam logic [1:0] TSTAT_STARVING  = 2'b00;
  localparam logic [1:0] TSTAT_SATISFIED = 2'b10;

  // Statistic counter slots
  localparam int NUM_CNT    = 8;
  localparam int C_RX_OCT   = 0;
  localparam int C_RX_JUMBO = 1;
  localparam int C_RX_CRC   = 2;
  localparam int C_RX_LONG  = 3;
  localparam int C_TX_OCT   = 4;
  localparam int C_TX_JUMBO = 5;
  localparam int C_TX_DROP  = 6;
  localparam int C_TX_CRC   = 7;

  // Negotiation states
  typedef enum logic [2:0] {
    AN_FORCED = 3'b001,
    AN_NEGOT  = 3'b010,
    AN_DONE   = 3'b100
  } gpl_an_state_t;

  // End-of-frame report from the data path
  typedef struct packed {
    logic [13:0] len;
    logic        vlan;
    logic        crc_bad;
  } gpl_frame_t;

endpackage : gpl_pkg

// ---- hw/gpl_port_link.sv ----
`timescale 1ns/100ps
`default_nettype none

module gpl_port_link (
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [15:0]       i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // Link side from PCS
  input  wire logic              i_rx_sync,
  input  wire logic              i_partner_ack,
  input  wire logic [15:0]       i_partner_word,
  output logic      [15:0]       o_adv_word,
  output logic                   o_cfg_send,
  output logic                   o_tx_enable,
  output logic                   o_link_valid,
  output logic                   o_link_led,
  // SPI4-2 side
  output logic      [1:0]        o_tstat,
  output logic                   o_rx_pass,
  // Frame reports
  input  wire logic              i_rx_eof,
  input  wire gpl_pkg::gpl_frame_t i_rx_frame,
  output logic                   o_rx_abort,
  input  wire logic              i_tx_eof,
  input  wire gpl_pkg::gpl_frame_t i_tx_frame,
  output logic                   o_tx_crc_append,
  output logic                   o_tx_drop,
  // Pause request
  input  wire logic              i_pause_req,
  input  wire logic              i_tx_busy,
  output logic                   o_pause_send
);

  logic                  sync_meta;
  logic                  sync_q;
  logic [13:0]           max_len;
  logic [31:0]           fc_en;
  logic [15:0]           adv_word;
  logic [31:0]           misc_cfg;
  logic [31:0]           led_en;
  logic                  an_sel_q;
  gpl_pkg::gpl_an_state_t an_state;
  logic                  an_done;
  logic                  link_ok;
  logic                  pause_pend;
  logic [31:0]           cnt [gpl_pkg::NUM_CNT];
  logic [gpl_pkg::NUM_CNT-1:0] inc;
  logic [gpl_pkg::NUM_CNT-1:0] rd_hit;
  logic [31:0]           inc_val [gpl_pkg::NUM_CNT];
  logic [14:0]           rx_lim;
  logic [14:0]           tx_lim;
  logic                  rx_long;
  logic                  tx_long;
  logic                  rx_jumbo;
  logic                  tx_jumbo;
  logic                  wr_acc;
  logic                  rd_acc;
  logic                  setup;
  logic [11:0]           idx;
  logic                  aligned;
  logic [31:0]           next_prdata;
  logic                  next_err;
  // Receive sync arrives from the recovered clock; two flops
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_meta <= 1'b0;
      sync_q    <= 1'b0;
    end else begin
      sync_meta <= i_rx_sync;
      sync_q    <= sync_meta;
    end
  end
  // Bus decode
  assign setup   = i_psel && !i_penable;
  assign wr_acc  = i_psel && i_penable && i_pwrite;
  assign rd_acc  = i_psel && i_penable && !i_pwrite;
  assign idx     = i_paddr[13:2];
  assign aligned = (i_paddr[1:0] == 2'b00) && (i_paddr[15:14] == 2'b00);
  // Software-written configuration
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      max_len  <= gpl_pkg::RST_MAX_FRAME;
      fc_en    <= gpl_pkg::RST_FLOW_CONTROL_ENABLE;
      adv_word <= 16'h0000;
      misc_cfg <= gpl_pkg::RST_MISC_CFG;
      led_en   <= 32'h0000_0000;
    end else if (wr_acc && aligned) begin
      if (idx == gpl_pkg::IDX_MAX_FRAME) begin
        max_len <= i_pwdata[13:0];
      end else if (idx == gpl_pkg::IDX_FLOW_CONTROL_ENABLE) begin
        fc_en <= i_pwdata;
      end else if (idx == gpl_pkg::IDX_ADV_CFG) begin
        adv_word <= i_pwdata[15:0];
      end else if (idx == gpl_pkg::IDX_MISC_CFG) begin
        misc_cfg <= i_pwdata;
      end else if (idx == gpl_pkg::IDX_LINK_LED) begin
        led_en <= i_pwdata;
      end
    end
  end
  // Negotiation state machine; select edge tracking for restart
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      an_state <= gpl_pkg::AN_FORCED;
      an_sel_q <= 1'b0;
    end else begin
      an_sel_q <= misc_cfg[gpl_pkg::BIT_AN_SELECT];
      case (an_state)
        gpl_pkg::AN_FORCED: begin
          if (misc_cfg[gpl_pkg::BIT_AN_SELECT] && !an_sel_q) begin
            an_state <= gpl_pkg::AN_NEGOT;
          end
        end
        gpl_pkg::AN_NEGOT: begin
          if (!misc_cfg[gpl_pkg::BIT_AN_SELECT]) begin
            an_state <= gpl_pkg::AN_FORCED;
          end else if (sync_q && i_partner_ack) begin
            an_state <= gpl_pkg::AN_DONE;
          end
        end
        gpl_pkg::AN_DONE: begin
          if (!misc_cfg[gpl_pkg::BIT_AN_SELECT]) begin
            an_state <= gpl_pkg::AN_FORCED;
          end else if (!sync_q) begin
            an_state <= gpl_pkg::AN_NEGOT;
          end
        end
        default: begin
          an_state <= gpl_pkg::AN_FORCED;
        end
      endcase
    end
  end
  // Done flag follows the done state; cleared on any restart
  assign an_done = (an_state == gpl_pkg::AN_DONE);
  assign link_ok = misc_cfg[gpl_pkg::BIT_AN_SELECT] ? (an_done && sync_q) : sync_q;
  // Link-facing outputs and transmit status
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_link_valid <= 1'b0;
      o_tx_enable  <= 1'b0;
      o_rx_pass    <= 1'b0;
      o_tstat      <= gpl_pkg::TSTAT_SATISFIED;
      o_adv_word   <= 16'h0000;
      o_cfg_send   <= 1'b0;
      o_link_led   <= 1'b0;
      o_tx_crc_append <= 1'b0;
    end else begin
      o_link_valid <= link_ok;
      o_tx_enable  <= link_ok;
      o_rx_pass    <= link_ok;
      o_tstat      <= link_ok ? gpl_pkg::TSTAT_STARVING : gpl_pkg::TSTAT_SATISFIED;
      o_adv_word   <= adv_word;
      o_cfg_send   <= (an_state == gpl_pkg::AN_NEGOT);
      o_link_led   <= led_en[0] && link_ok;
      o_tx_crc_append <= misc_cfg[gpl_pkg::BIT_TX_CRC_APP];
    end
  end
  // Length limits, VLAN adds four bytes
  assign rx_lim   = {1'b0, max_len} + (i_rx_frame.vlan ? gpl_pkg::VLAN_EXTRA : 15'h0000);
  assign tx_lim   = {1'b0, max_len} + (i_tx_frame.vlan ? gpl_pkg::VLAN_EXTRA : 15'h0000);
  assign rx_long  = {1'b0, i_rx_frame.len} > rx_lim;
  assign tx_long  = {1'b0, i_tx_frame.len} > tx_lim;
  assign rx_jumbo = !rx_long && ({1'b0, i_rx_frame.len} >= gpl_pkg::JUMBO_MIN_LEN);
  assign tx_jumbo = !tx_long && ({1'b0, i_tx_frame.len} >= gpl_pkg::JUMBO_MIN_LEN);
  // Counter increment events
  always_comb begin
    inc = '0;
    inc[gpl_pkg::C_RX_OCT]   = i_rx_eof && !rx_long && !i_rx_frame.crc_bad;
    inc[gpl_pkg::C_RX_JUMBO] = i_rx_eof && rx_jumbo;
    inc[gpl_pkg::C_RX_CRC]   = i_rx_eof && !rx_long && i_rx_frame.crc_bad;
    inc[gpl_pkg::C_RX_LONG]  = i_rx_eof && rx_long;
    inc[gpl_pkg::C_TX_OCT]   = i_tx_eof && !tx_long;
    inc[gpl_pkg::C_TX_JUMBO] = i_tx_eof && tx_jumbo;
    inc[gpl_pkg::C_TX_DROP]  = i_tx_eof && tx_long;
    inc[gpl_pkg::C_TX_CRC]   = i_tx_eof && !tx_long && i_tx_frame.crc_bad
                               && !misc_cfg[gpl_pkg::BIT_TX_CRC_APP];
  end
  // Counter read hits clear the slot
  always_comb begin
    rd_hit = '0;
    rd_hit[gpl_pkg::C_RX_OCT]   = idx == gpl_pkg::IDX_RX_OCTETS;
    rd_hit[gpl_pkg::C_RX_JUMBO] = idx == gpl_pkg::IDX_RX_JUMBO;
    rd_hit[gpl_pkg::C_RX_CRC]   = idx == gpl_pkg::IDX_RX_CRC_ERR;
    rd_hit[gpl_pkg::C_RX_LONG]  = idx == gpl_pkg::IDX_RX_LONG;
    rd_hit[gpl_pkg::C_TX_OCT]   = idx == gpl_pkg::IDX_TX_OCTETS;
    rd_hit[gpl_pkg::C_TX_JUMBO] = idx == gpl_pkg::IDX_TX_JUMBO;
    rd_hit[gpl_pkg::C_TX_DROP]  = idx == gpl_pkg::IDX_TX_LONG_DRP;
    rd_hit[gpl_pkg::C_TX_CRC]   = idx == gpl_pkg::IDX_TX_CRC_ERR;
    rd_hit = rd_hit & {gpl_pkg::NUM_CNT{rd_acc && aligned}};
  end
  // Octet slots add the length, others count frames
  assign inc_val[gpl_pkg::C_RX_OCT] = {18'h0_0000, i_rx_frame.len};
  assign inc_val[gpl_pkg::C_TX_OCT] = {18'h0_0000, i_tx_frame.len};
  assign inc_val[1] = 32'h0000_0001;
  assign inc_val[2] = 32'h0000_0001;
  assign inc_val[3] = 32'h0000_0001;
  assign inc_val[5] = 32'h0000_0001;
  assign inc_val[6] = 32'h0000_0001;
  assign inc_val[7] = 32'h0000_0001;
  // Clear-on-read counters; an event in the read cycle is kept
  for (genvar g = 0; g < gpl_pkg::NUM_CNT; g++) begin : g_cnt
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        cnt[g] <= 32'h0000_0000;
      end else if (rd_hit[g]) begin
        cnt[g] <= inc[g] ? inc_val[g] : 32'h0000_0000;
      end else if (inc[g]) begin
        cnt[g] <= cnt[g] + inc_val[g];
      end
    end
  end
  // Frame outcome strobes
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rx_abort <= 1'b0;
      o_tx_drop  <= 1'b0;
    end else begin
      o_rx_abort <= i_rx_eof && (i_rx_frame.crc_bad || rx_long);
      o_tx_drop  <= i_tx_eof && tx_long;
    end
  end
  // Pause waits for the frame in flight; new request wins over issue
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pause_pend   <= 1'b0;
      o_pause_send <= 1'b0;
    end else begin
      o_pause_send <= pause_pend && !i_tx_busy;
      if (i_pause_req && fc_en[gpl_pkg::BIT_FC_TX]) begin
        pause_pend <= 1'b1;
      end else if (!i_tx_busy) begin
        pause_pend <= 1'b0;
      end
    end
  end
  // Read mux, address decoded in the setup phase
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_err    = 1'b0;
    if (!aligned) begin
      next_err = 1'b1;
    end else if (idx == gpl_pkg::IDX_MAX_FRAME) begin
      next_prdata = {18'h0_0000, max_len};
    end else if (idx == gpl_pkg::IDX_FLOW_CONTROL_ENABLE) begin
      next_prdata = fc_en;
    end else if (idx == gpl_pkg::IDX_RX_CFG) begin
      next_prdata[15:0]                  = i_partner_word;
      next_prdata[gpl_pkg::BIT_RX_SYNC]  = sync_q;
      next_prdata[gpl_pkg::BIT_AN_DONE]  = an_done;
    end else if (idx == gpl_pkg::IDX_ADV_CFG) begin
      next_prdata = {16'h0000, adv_word};
    end else if (idx == gpl_pkg::IDX_MISC_CFG) begin
      next_prdata = misc_cfg;
    end else if (idx == gpl_pkg::IDX_LINK_LED) begin
      next_prdata = led_en;
    end else if (idx == gpl_pkg::IDX_RX_OCTETS) begin
      next_prdata = cnt[gpl_pkg::C_RX_OCT];
    end else if (idx == gpl_pkg::IDX_RX_JUMBO) begin
      next_prdata = cnt[gpl_pkg::C_RX_JUMBO];
    end else if (idx == gpl_pkg::IDX_RX_CRC_ERR) begin
      next_prdata = cnt[gpl_pkg::C_RX_CRC];
    end else if (idx == gpl_pkg::IDX_RX_LONG) begin
      next_prdata = cnt[gpl_pkg::C_RX_LONG];
    end else if (idx == gpl_pkg::IDX_TX_OCTETS) begin
      next_prdata = cnt[gpl_pkg::C_TX_OCT];
    end else if (idx == gpl_pkg::IDX_TX_JUMBO) begin
      next_prdata = cnt[gpl_pkg::C_TX_JUMBO];
    end else if (idx == gpl_pkg::IDX_TX_LONG_DRP) begin
      next_prdata = cnt[gpl_pkg::C_TX_DROP];
    end else if (idx == gpl_pkg::IDX_TX_CRC_ERR) begin
      next_prdata = cnt[gpl_pkg::C_TX_CRC];
    end else if ((idx == gpl_pkg::IDX_RX_DATA_ERR) || (idx == gpl_pkg::IDX_RX_ALIGN) ||
                 (idx == gpl_pkg::IDX_RX_JABBER) || (idx == gpl_pkg::IDX_RX_VLONG)) begin
      next_prdata = 32'h0000_0000; // Counters not kept by this block
    end else begin
      next_err = 1'b1;
    end
  end
  // Bus answer: data captured at setup, ready in the access cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata  <= 32'h0000_0000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= setup;
      o_pslverr <= setup && next_err;
      if (setup && !i_pwrite) begin
        o_prdata <= next_prdata;
      end
    end
  end
  // Checks
  sequence s_sync_lost;
    $past(sync_q) && !sync_q;
  endsequence

  sequence s_reselect;
    !misc_cfg[gpl_pkg::BIT_AN_SELECT] ##1 misc_cfg[gpl_pkg::BIT_AN_SELECT];
  endsequence

  a_forced_reset: assert property (@(posedge i_sys_clk) $rose(i_rst_n) |->
    an_state == gpl_pkg::AN_FORCED) else $error("Not forced after reset");
  a_done_needs_sync: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    misc_cfg[gpl_pkg::BIT_AN_SELECT] && !(an_done && sync_q) |=> !o_link_valid)
    else $error("Link valid without done and sync");
  a_tstat_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !link_ok |=> o_tstat == gpl_pkg::TSTAT_SATISFIED) else $error("Status released early");
  a_forced_tstat: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !misc_cfg[gpl_pkg::BIT_AN_SELECT] && sync_q |=> o_tstat == gpl_pkg::TSTAT_STARVING)
    else $error("Forced status not released on sync");
  a_loss_restart: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    an_state == gpl_pkg::AN_DONE && misc_cfg[gpl_pkg::BIT_AN_SELECT] ##1 s_sync_lost
    |=> an_state == gpl_pkg::AN_NEGOT) else $error("No restart on sync loss");
  a_manual_restart: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_reselect |=> ##1 !an_done) else $error("Reselect did not restart");
  a_done_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    an_done && !(sync_q && misc_cfg[gpl_pkg::BIT_AN_SELECT]) |=> !an_done)
    else $error("Done kept after restart");
  a_vlan_limit: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_rx_eof && i_rx_frame.vlan && ({1'b0, i_rx_frame.len} == {1'b0, max_len} + 15'h0004)
    && !i_rx_frame.crc_bad |=> !o_rx_abort) else $error("VLAN frame at limit aborted");
  a_crc_abort: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_rx_eof && i_rx_frame.crc_bad |=> o_rx_abort) else $error("Bad CRC not aborted");
  a_pause_wait: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_pause_send |-> !$past(i_tx_busy)) else $error("Pause sent during frame");
  a_forced_tx: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (!misc_cfg[gpl_pkg::BIT_AN_SELECT] && !sync_q) [*2] |-> !o_tx_enable [*2])
    else $error("Transmit enabled without sync");

endmodule : gpl_port_link

`default_nettype wire

// ---- verification/gpl_link_partner.sv ----
`timescale 1ns/100ps
`default_nettype none
// Behavioural fiber link partner as seen through the PCS
module gpl_link_partner #(
  parameter logic [15:0] PARTNER_WORD = 16'h01A0
) (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // Bench control
  input  wire logic        i_in_sync,
  input  wire logic        i_slow,
  // Device side
  input  wire logic        i_cfg_send,
  input  wire logic [15:0] i_adv_word,
  output logic             o_rx_sync,
  output logic             o_partner_ack,
  output logic [15:0]      o_partner_word
);
  logic [7:0] ack_cnt;
  // Acknowledge only after hearing a non-empty advertisement for a while
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) ack_cnt <= 8'h00;
    else if (!i_cfg_send || !i_in_sync || i_adv_word == 16'h0000) ack_cnt <= 8'h00;
    else if (ack_cnt != 8'hFF) ack_cnt <= ack_cnt + 8'h01;
  end
  assign o_partner_ack = ack_cnt > (i_slow ? 8'h28 : 8'h04);
  // Base page is only meaningful in sync; otherwise the word churns
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_partner_word <= 16'h0000;
    else o_partner_word <= i_in_sync ? PARTNER_WORD : ~o_partner_word;
  end
  assign o_rx_sync = i_in_sync;
endmodule : gpl_link_partner
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic                i_sys_clk, i_rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [15:0]         paddr, pword, adv;
  logic [31:0]         pwdata, prdata, rd;
  logic [1:0]          tstat;
  logic                rx_sync, ack, cfg_send, tx_en, link_valid, led, rx_pass, in_sync, slow;
  logic                rx_eof, rx_abort, tx_eof, crc_app, tx_drop, pause_req, tx_busy, pause_send;
  gpl_pkg::gpl_frame_t rx_frame, tx_frame;
  int                  n_errors, check_count, cycles;

  gpl_port_link uut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_rx_sync(rx_sync),
    .i_partner_ack(ack), .i_partner_word(pword), .o_adv_word(adv), .o_cfg_send(cfg_send),
    .o_tx_enable(tx_en), .o_link_valid(link_valid), .o_link_led(led), .o_tstat(tstat),
    .o_rx_pass(rx_pass), .i_rx_eof(rx_eof), .i_rx_frame(rx_frame), .o_rx_abort(rx_abort),
    .i_tx_eof(tx_eof), .i_tx_frame(tx_frame), .o_tx_crc_append(crc_app),
    .o_tx_drop(tx_drop), .i_pause_req(pause_req), .i_tx_busy(tx_busy),
    .o_pause_send(pause_send));
  gpl_link_partner partner (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_in_sync(in_sync),
    .i_slow(slow), .i_cfg_send(cfg_send), .i_adv_word(adv), .o_rx_sync(rx_sync),
    .o_partner_ack(ack), .o_partner_word(pword));

  // Clock source
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  // Hang guard
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; waits for pready, the hang guard bounds the wait
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    @(posedge i_sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdchk
  // Poll the done flag a bounded number of times
  task automatic poll_done();
    int n;
    rd = 32'h0000_0000;
    n = 0;
    while (rd[gpl_pkg::BIT_AN_DONE] !== 1'b1 && n < 60) begin
      apb(1'b0, gpl_pkg::IDX_RX_CFG, 32'h0000_0000);
      n++;
    end
  endtask : poll_done
  // One end-of-frame report, then the one-cycle verdict pulse
  task automatic frm(input logic tx, input logic [13:0] len, input logic vl,
                     input logic bad, input logic exp);
    @(posedge i_sys_clk);
    rx_eof   <= !tx;
    tx_eof   <= tx;
    rx_frame <= {len, vl, bad};
    tx_frame <= {len, vl, bad};
    @(posedge i_sys_clk);
    rx_eof <= 1'b0;
    tx_eof <= 1'b0;
    #1 chk(tx ? tx_drop : rx_abort, exp);
  endtask : frm

  // Main sequence
  initial begin
    {psel, penable, pwrite, rx_eof, tx_eof, pause_req, tx_busy, in_sync, slow} = '0;
    {paddr, pwdata, rx_frame, tx_frame} = '0;
    {n_errors, check_count, cycles} = '0;
    i_rst_n = 1'b0;
    repeat (6) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rdchk(gpl_pkg::IDX_MAX_FRAME, 32'h0000_05EE);
    rdchk(gpl_pkg::IDX_MISC_CFG, 32'h0000_0000);
    chk(tstat, gpl_pkg::TSTAT_SATISFIED);
    apb(1'b0, 12'h3FF, 32'h0000_0000);
    chk(err, 1'b1);
    $display("end of reset test");
    rdchk(gpl_pkg::IDX_RX_CFG, 32'h0000_0000);
    in_sync <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
    apb(1'b0, gpl_pkg::IDX_RX_CFG, 32'h0000_0000);
    chk(rd, 32'h0010_01A0);
    chk(tx_en, 1'b1);
    chk(rx_pass, 1'b1);
    chk(tstat, gpl_pkg::TSTAT_STARVING);
    in_sync <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
    chk(tstat, gpl_pkg::TSTAT_SATISFIED);
    chk(rx_pass, 1'b0);
    apb(1'b0, gpl_pkg::IDX_RX_CFG, 32'h0000_0000);
    chk(rd[20], 1'b0);
    $display("end of forced mode test");
    apb(1'b1, gpl_pkg::IDX_ADV_CFG, 32'h0000_01A0);
    apb(1'b1, gpl_pkg::IDX_MISC_CFG, 32'h0000_0020);
    chk(adv, 16'h01A0);
    slow    <= 1'b1;
    in_sync <= 1'b1;
    repeat (12) @(posedge i_sys_clk);
    chk(cfg_send, 1'b1);
    chk(tstat, gpl_pkg::TSTAT_SATISFIED);
    chk(link_valid, 1'b0);
    poll_done();
    chk(rd[21:20], 2'b11);
    repeat (4) @(posedge i_sys_clk);
    chk(link_valid, 1'b1);
    chk(tstat, gpl_pkg::TSTAT_STARVING);
    apb(1'b1, gpl_pkg::IDX_LINK_LED, 32'h0000_0001);
    repeat (3) @(posedge i_sys_clk);
    chk(led, 1'b1);
    in_sync <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
    apb(1'b0, gpl_pkg::IDX_RX_CFG, 32'h0000_0000);
    chk(rd[21:20], 2'b00);
    chk(cfg_send, 1'b1);
    chk(tstat, gpl_pkg::TSTAT_SATISFIED);
    in_sync <= 1'b1;
    poll_done();
    chk(rd[21:20], 2'b11);
    apb(1'b1, gpl_pkg::IDX_MISC_CFG, 32'h0000_0000);
    apb(1'b1, gpl_pkg::IDX_MISC_CFG, 32'h0000_0020);
    apb(1'b0, gpl_pkg::IDX_RX_CFG, 32'h0000_0000);
    chk(rd[21], 1'b0);
    poll_done();
    chk(rd[21], 1'b1);
    $display("end of negotiation test");
    apb(1'b1, gpl_pkg::IDX_MAX_FRAME, 32'h0000_2667);
    rdchk(gpl_pkg::IDX_MAX_FRAME, 32'h0000_2667);
    frm(1'b0, 14'h2667, 1'b0, 1'b0, 1'b0);
    frm(1'b0, 14'h2668, 1'b0, 1'b0, 1'b1);
    frm(1'b0, 14'h266B, 1'b1, 1'b0, 1'b0);
    frm(1'b0, 14'h266C, 1'b1, 1'b0, 1'b1);
    frm(1'b0, 14'h05EF, 1'b0, 1'b1, 1'b1);
    rdchk(gpl_pkg::IDX_RX_CRC_ERR, 32'h0000_0001);
    rdchk(gpl_pkg::IDX_RX_CRC_ERR, 32'h0000_0000);
    rdchk(gpl_pkg::IDX_RX_JUMBO, 32'h0000_0003);
    frm(1'b1, 14'h0100, 1'b0, 1'b1, 1'b0);
    rdchk(gpl_pkg::IDX_TX_CRC_ERR, 32'h0000_0001);
    apb(1'b1, gpl_pkg::IDX_MISC_CFG, 32'h0000_0060);
    repeat (2) @(posedge i_sys_clk);
    chk(crc_app, 1'b1);
    frm(1'b1, 14'h2668, 1'b0, 1'b0, 1'b1);
    $display("end of frame test");
    @(posedge i_sys_clk);
    tx_busy   <= 1'b1;
    pause_req <= 1'b1;
    @(posedge i_sys_clk);
    pause_req <= 1'b0;
    repeat (5) begin
      @(posedge i_sys_clk);
      #1 chk(pause_send, 1'b0);
    end
    @(posedge i_sys_clk);
    tx_busy <= 1'b0;
    @(posedge i_sys_clk);
    #1 chk(pause_send, 1'b1);
    $display("end of pause test");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
